/* include/fcc_pkg.sv */
// Constants, register map and carrier types of the FIFO channel control block.
package fcc_pkg;
   // Array and counter sizes.
   localparam int NUM_FIFO = 32;
   localparam int FIFO_W   = 5;
   localparam int CNT_W    = 12;
   localparam int FRM_W    = 5;
   localparam int CTRL_W   = 6;
   // Register offsets.
   localparam logic [7:0] ADDR_SELECT  = 8'hf0;
   localparam logic [7:0] ADDR_SEQ     = 8'hf1;
   localparam logic [7:0] ADDR_GLOBAL  = 8'hf2;
   localparam logic [7:0] ADDR_STATE   = 8'hf3;
   localparam logic [7:0] ADDR_IRQ_STA = 8'hf4;
   localparam logic [7:0] ADDR_IRQ_MSK = 8'hf8;
   localparam logic [7:0] ADDR_CTRL    = 8'hff;
   localparam logic [7:0] VEC_BYTES    = 8'h04;
   // Sequence entry fields.
   localparam int         SEQ_DIR_BIT = 0;
   localparam int         SEQ_END_BIT = 6;
   localparam logic [7:0] SEQ_WMASK   = 8'h5f;
   // Control fields.
   localparam int CTRL_IRQMSK = 0;
   localparam int CTRL_BERT   = 1;
   localparam int CTRL_MIX    = 2;
   localparam int CTRL_ABORT  = 3;
   localparam int CTRL_NOCRC  = 4;
   localparam int CTRL_NOREP  = 5;
   // Global control fields.
   localparam int GLB_SEQ_MODE  = 0;
   localparam int GLB_IRQ_EN    = 1;
   localparam int GLB_START_LSB = 3;
   localparam logic [7:0] GLB_RESET = 8'h00;
   // Fifo state fields.
   localparam int STATE_ERR_BIT = 0;
   // Timing and encodings.
   localparam int         THR_BASE       = 3;
   localparam logic [4:0] ABORT_ONES     = 5'h10;
   localparam logic [2:0] RX_ABORT_RUN   = 3'h7;
   localparam logic [7:0] STATUS_ABORT   = 8'hff;
   localparam logic [7:0] STATUS_CRC_ERR = 8'h01;
   localparam logic [7:0] STATUS_OK      = 8'h00;

   // One event from the core for one fifo.
   typedef struct packed {
      logic              valid;
      logic [FIFO_W-1:0] fifo;
      logic              hdlc;
      logic              frame_end;
      logic              byte_step;
      logic              in_frame;
      logic              frame_inc_ok;
      logic              crc_err;
      logic              contention_lost;
      logic [2:0]        irq_thr;
      logic [CNT_W-1:0]  byte_write_counter;
      logic [CNT_W-1:0]  byte_read_counter;
      logic [FRM_W-1:0]  frame_write_counter;
      logic [FRM_W-1:0]  frame_read_counter;
   } fcc_event_t;

   // Settings of the fifo named on the event port in the previous cycle, valid or not.
   typedef struct packed {
      logic              bit_error_test_enable;
      logic              crc_suppress;
      logic [FIFO_W-1:0] fifo;
   } fcc_cfg_t;

   // Sequence position.
   typedef struct packed {
      logic              active;
      logic [FIFO_W-1:0] fifo;
      logic              last;
   } fcc_seq_t;

   typedef enum logic {ABT_IDLE, ABT_SEND} fcc_abort_t;
endpackage

/* verilog/fcc_channel_control.sv */
// Per-fifo settings, sequence list, interrupts and abort handling of the fifo controller.
module fcc_channel_control (
   input  wire logic                 core_clk,
   input  wire logic                 reset_n,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [7:0]                reg_rdata,
   input  wire fcc_pkg::fcc_event_t  ev,
   input  wire logic                 tx_bit_tick,
   input  wire logic                 rx_bit_tick,
   input  wire logic                 rx_bit,
   input  wire logic                 seq_advance,
   output fcc_pkg::fcc_cfg_t         cfg_out,
   output logic                      tx_force_ones,
   output logic                      rx_status_valid,
   output logic [7:0]                rx_status_byte,
   output logic                      repeat_frame,
   output logic                      abort_frame,
   output fcc_pkg::fcc_seq_t         seq_out,
   output logic                      irq
);
   import fcc_pkg::*;

   logic                rst_s1_q;
   logic                rst_s2_q;
   logic                rst_n;
   logic [FIFO_W-1:0]   sel_q;
   logic [7:0]          seq_q [NUM_FIFO];
   logic [CTRL_W-1:0]   ctrl_q [NUM_FIFO];
   logic [7:0]          glb_q;
   logic [NUM_FIFO-1:0] sta_q;
   logic [NUM_FIFO-1:0] err_q;
   logic [NUM_FIFO-1:0] msk;
   logic [NUM_FIFO-1:0] sta_clr;
   logic [NUM_FIFO-1:0] sta_set;
   logic [NUM_FIFO-1:0] err_set;
   logic [NUM_FIFO-1:0] err_clr;
   logic [7:0]          rdata_d;
   logic [7:0]          rdata_q;
   logic [CTRL_W-1:0]   ev_cfg;
   logic                ev_rx;
   logic                wrap;
   logic                irq_ev;
   logic                underrun;
   logic                rx_end;
   fcc_abort_t          abt_q;
   logic [4:0]          abt_cnt_q;
   logic [2:0]          ones_q;
   logic                seen_q;
   logic [FIFO_W-1:0]   cur_q;
   logic [FIFO_W-1:0]   start;
   logic                seq_mode;
   logic [7:0]          cur_entry;
   fcc_cfg_t            cfg_q;
   logic                stat_v_q;
   logic [7:0]          stat_q;
   logic                rep_q;
   logic                abo_q;

   // True when the address falls into the four bytes of a 32-bit vector.
   function automatic logic in_vec(input logic [7:0] a, input logic [7:0] base);
      in_vec = (a >= base) && (a < base + VEC_BYTES);
   endfunction

   // Picks byte k of a 32-bit vector.
   function automatic logic [7:0] vec_byte(input logic [31:0] v, input logic [1:0] k);
      vec_byte = v[{k, 3'b000} +: 8];
   endfunction

   // Spreads a written byte to its lanes of a 32-bit vector.
   function automatic logic [31:0] byte_vec(input logic [7:0] b, input logic [1:0] k);
      byte_vec = {24'h000000, b} << {k, 3'b000};
   endfunction

   // One-hot flag for a fifo index.
   function automatic logic [31:0] onehot(input logic [FIFO_W-1:0] i);
      onehot = 32'h00000001 << i;
   endfunction

   // Low n bits of a counter are all zero, n being the threshold plus base.
   function automatic logic low_zero(input logic [CNT_W-1:0] c, input logic [2:0] thr);
      logic [CNT_W-1:0] m;
      m = CNT_W'((13'h0001 << (4'(thr) + 4'(THR_BASE))) - 13'h0001);
      low_zero = (c & m) == '0;
   endfunction

   // Releases the asynchronous reset through two flip-flops.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // Fifo selection register for the array registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= '0;
      end else if (reg_wr && reg_addr == ADDR_SELECT) begin
         sel_q <= reg_wdata[FIFO_W-1:0];
      end
   end

   // Sequence entries reset to point at their own fifo.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_FIFO; i++) begin
            seq_q[i] <= {3'b000, 5'(i)};
         end
      end else if (reg_wr && reg_addr == ADDR_SEQ) begin
         seq_q[sel_q] <= reg_wdata & SEQ_WMASK;
      end
   end

   // Per-fifo control array.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_FIFO; i++) begin
            ctrl_q[i] <= '0;
         end
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
         ctrl_q[sel_q] <= reg_wdata[CTRL_W-1:0];
      end
   end

   // Global mode, interrupt enable and sequence start.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         glb_q <= GLB_RESET;
      end else if (reg_wr && reg_addr == ADDR_GLOBAL) begin
         glb_q <= reg_wdata;
      end
   end

   // Write-one-to-clear strobes and the per-fifo mask vector.
   always_comb begin
      sta_clr = '0;
      err_clr = '0;
      for (int i = 0; i < NUM_FIFO; i++) begin
         msk[i] = ctrl_q[i][CTRL_IRQMSK];
      end
      if (reg_wr && in_vec(reg_addr, ADDR_IRQ_STA)) begin
         sta_clr = byte_vec(reg_wdata, reg_addr[1:0]);
      end
      if (reg_wr && reg_addr == ADDR_STATE && reg_wdata[STATE_ERR_BIT]) begin
         err_clr = onehot(sel_q);
      end
   end

   // Sticky interrupt and error flags; a set beats a clear in the same cycle.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sta_q <= '0;
         err_q <= '0;
      end else begin
         sta_q <= (sta_q & ~sta_clr) | sta_set;
         err_q <= (err_q & ~err_clr) | err_set;
      end
   end

   // Read multiplexer; unmapped addresses read zero.
   always_comb begin
      rdata_d = 8'h00;
      if (reg_addr == ADDR_SELECT) begin
         rdata_d = {3'b000, sel_q};
      end else if (reg_addr == ADDR_SEQ) begin
         rdata_d = seq_q[sel_q];
      end else if (reg_addr == ADDR_GLOBAL) begin
         rdata_d = glb_q;
      end else if (reg_addr == ADDR_STATE) begin
         rdata_d = {7'h00, err_q[sel_q]};
      end else if (in_vec(reg_addr, ADDR_IRQ_STA)) begin
         rdata_d = vec_byte(sta_q, reg_addr[1:0]);
      end else if (in_vec(reg_addr, ADDR_IRQ_MSK)) begin
         rdata_d = vec_byte(msk, reg_addr[1:0]);
      end else if (reg_addr == ADDR_CTRL) begin
         rdata_d = {2'b00, ctrl_q[sel_q]};
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd ? rdata_d : 8'h00;
      end
   end
   assign reg_rdata = rdata_q;

   // Event decode for the fifo that the core is serving.
   always_comb begin
      ev_cfg = ctrl_q[ev.fifo];
      ev_rx  = ev.fifo[0];
      wrap = ev.byte_step && low_zero(ev_rx ? ev.byte_write_counter : ev.byte_read_counter,
                                      ev.irq_thr);
      irq_ev = ev.valid && (ev.hdlc ? (ev.frame_end || (ev_cfg[CTRL_MIX] && wrap)) : wrap);
      underrun = ev.valid && !ev_rx && ev.in_frame && !ev.frame_inc_ok
                 && ev.byte_write_counter == ev.byte_read_counter
                 && ev.frame_write_counter == ev.frame_read_counter;
      rx_end  = ev.valid && ev_rx && ev.hdlc && ev.frame_end;
      sta_set = irq_ev ? onehot(ev.fifo) : '0;
      err_set = underrun ? onehot(ev.fifo) : '0;
   end

   assign irq = glb_q[GLB_IRQ_EN] && ((sta_q & msk) != '0);

   // Frame abort: force ones for sixteen bit times after an underrun.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         abt_q     <= ABT_IDLE;
         abt_cnt_q <= '0;
      end else begin
         unique case (abt_q)
            ABT_IDLE: begin
               if (underrun && ev_cfg[CTRL_ABORT]) begin
                  abt_q     <= ABT_SEND;
                  abt_cnt_q <= '0;
               end
            end
            ABT_SEND: begin
               if (tx_bit_tick) begin
                  abt_cnt_q <= abt_cnt_q + 5'h01;
                  if (abt_cnt_q == ABORT_ONES - 5'h01) begin
                     abt_q <= ABT_IDLE;
                  end
               end
            end
         endcase
      end
   end
   assign tx_force_ones = (abt_q == ABT_SEND);

   // Receive run of ones, saturating; a run of seven marks the frame aborted.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ones_q <= '0;
         seen_q <= 1'b0;
      end else begin
         if (rx_bit_tick) begin
            ones_q <= !rx_bit ? 3'h0 : (ones_q == RX_ABORT_RUN) ? ones_q : ones_q + 3'h1;
         end else if (rx_end) begin
            ones_q <= '0;
         end
         if (ones_q == RX_ABORT_RUN && !rx_end) begin
            seen_q <= 1'b1;
         end else if (rx_end) begin
            seen_q <= 1'b0;
         end
      end
   end

   // Receive status byte at frame end.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_v_q <= 1'b0;
         stat_q   <= STATUS_OK;
      end else begin
         stat_v_q <= rx_end;
         if (rx_end) begin
            if (ev_cfg[CTRL_ABORT] && (seen_q || ones_q == RX_ABORT_RUN)) begin
               stat_q <= STATUS_ABORT;
            end else begin
               stat_q <= ev.crc_err ? STATUS_CRC_ERR : STATUS_OK;
            end
         end
      end
   end
   assign rx_status_valid = stat_v_q;
   assign rx_status_byte  = stat_q;

   // Lost D-channel contention: repeat or abort.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rep_q <= 1'b0;
         abo_q <= 1'b0;
      end else begin
         rep_q <= ev.valid && !ev_rx && ev.contention_lost && !ev_cfg[CTRL_NOREP];
         abo_q <= ev.valid && !ev_rx && ev.contention_lost && ev_cfg[CTRL_NOREP];
      end
   end
   assign repeat_frame = rep_q;
   assign abort_frame  = abo_q;

   // Data-path settings of the fifo being served.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= '0;
      end else begin
         cfg_q.bit_error_test_enable <= ev_cfg[CTRL_BERT];
         cfg_q.crc_suppress <= ev_cfg[CTRL_NOCRC];
         cfg_q.fifo         <= ev.fifo;
      end
   end
   assign cfg_out = cfg_q;

   assign start     = glb_q[GLB_START_LSB +: FIFO_W];
   assign seq_mode  = glb_q[GLB_SEQ_MODE];
   assign cur_entry = seq_q[cur_q];

   // Sequence walker over the linked entries.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_q <= '0;
      end else if (!seq_mode) begin
         cur_q <= start;
      end else if (seq_advance) begin
         cur_q <= cur_entry[SEQ_END_BIT] ? start : cur_entry[FIFO_W-1:0];
      end
   end
   assign seq_out = '{active: seq_mode, fifo: cur_q, last: cur_entry[SEQ_END_BIT]};

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_adv;
      seq_mode && seq_advance;
   endsequence
   sequence s_underrun_abort;
      underrun && ev_cfg[CTRL_ABORT] && abt_q == ABT_IDLE;
   endsequence

   property p_seq_follow;
      s_adv and !cur_entry[SEQ_END_BIT] |=> cur_q == $past(cur_entry[FIFO_W-1:0]);
   endproperty
   a_seq_follow: assert property (p_seq_follow) else $error("sequence did not follow pointer");
   property p_seq_end;
      s_adv and cur_entry[SEQ_END_BIT] |=> cur_q == $past(start);
   endproperty
   a_seq_end: assert property (p_seq_end) else $error("sequence did not end");
   property p_seq_idle;
      !seq_mode ##1 !seq_mode |-> cur_q == $past(start) && !seq_out.active;
   endproperty
   a_seq_idle: assert property (p_seq_idle) else $error("sequence moved outside mode");
   property p_irq_gate;
      !glb_q[GLB_IRQ_EN] || (sta_q & msk) == '0 |-> !irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");
   property p_irq_set;
      irq_ev && ctrl_q[ev.fifo][CTRL_IRQMSK] && glb_q[GLB_IRQ_EN] ##1 glb_q[GLB_IRQ_EN] |-> irq;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("unmasked event gave no interrupt");
   property p_abort_start;
      s_underrun_abort |=> tx_force_ones [*2];
   endproperty
   a_abort_start: assert property (p_abort_start) else $error("abort run not started");
   property p_abort_len;
      $fell(tx_force_ones) |-> $past(abt_cnt_q) == ABORT_ONES - 5'h01 && $past(tx_bit_tick);
   endproperty
   a_abort_len: assert property (p_abort_len) else $error("abort run too short");
   property p_err_flag;
      underrun |=> err_q[$past(ev.fifo)];
   endproperty
   a_err_flag: assert property (p_err_flag) else $error("empty error not flagged");
   property p_status_ff;
      rx_end && ev_cfg[CTRL_ABORT] && seen_q |=> rx_status_valid && rx_status_byte == STATUS_ABORT;
   endproperty
   a_status_ff: assert property (p_status_ff) else $error("abort status not ff");
   property p_no_rep;
      ev.valid && !ev_rx && ev.contention_lost |=> repeat_frame != abort_frame;
   endproperty
   a_no_rep: assert property (p_no_rep) else $error("contention outcome wrong");
endmodule

/* bench/fcc_host_model.sv */
// Host processor model that drives the register port of the fifo channel control.
module fcc_host_model (
   input  wire logic       core_clk,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import fcc_pkg::*;

   // The bus is idle from time zero.
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // One write cycle, released at the edge that takes it.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   // One read cycle; the data are taken in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic sel(input logic [4:0] f);
      wr(ADDR_SELECT, {3'h0, f});
   endtask

   task automatic put(input logic [4:0] f, input logic [7:0] seq, input logic [7:0] ctrl,
                      input logic hdlc);
      sel(f);
      wr(ADDR_SEQ, seq & SEQ_WMASK);
      wr(ADDR_CTRL, hdlc ? ctrl : (ctrl & 8'hfb));
   endtask
endmodule

/* bench/fcc_channel_control_tb.sv */
// Self-checking testbench of the fifo channel control block.
module fcc_channel_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fcc_pkg::*;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] glb;
      logic       irq;
      logic       bert;
      logic       nocrc;
      logic       rep;
      logic       abt;
   } fcc_row_t;

   localparam fcc_row_t ROWS [5] = '{
      '{8'h00, 8'h02, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
      '{8'h01, 8'h02, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0},
      '{8'h01, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
      '{8'h22, 8'h02, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
      '{8'h11, 8'h02, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0}};

   logic       core_clk;
   logic       reset_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   fcc_event_t ev;
   fcc_event_t e;
   logic       tx_bit_tick;
   logic       rx_bit_tick;
   logic       rx_bit;
   logic       seq_advance;
   fcc_cfg_t   cfg_out;
   logic       tx_force_ones;
   logic       rx_status_valid;
   logic [7:0] rx_status_byte;
   logic       repeat_frame;
   logic       abort_frame;
   fcc_seq_t   seq_out;
   logic       irq;
   logic [7:0] d;
   int         n_mismatch = 0;
   int         tests_run = 0;
   int         cycles = 0;

   fcc_channel_control u_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ev(ev), .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick), .rx_bit(rx_bit),
      .seq_advance(seq_advance), .cfg_out(cfg_out), .tx_force_ones(tx_force_ones),
      .rx_status_valid(rx_status_valid), .rx_status_byte(rx_status_byte),
      .repeat_frame(repeat_frame), .abort_frame(abort_frame), .seq_out(seq_out), .irq(irq));

   fcc_host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // Free-running core clock at 50 MHz.
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Cuts a hung run short.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 10000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk1(input logic g, input logic x);
      tests_run++;
      if (g !== x) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: bit is %b, expected %b", $time, g, x);
      end
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] x);
      tests_run++;
      if (g !== x) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: byte is %h, expected %h", $time, g, x);
      end
   endtask

   task automatic reg_is(input logic [7:0] a, input logic [7:0] x);
      u_host.rd(a, d);
      chk8(d, x);
   endtask

   task automatic seq_is(input logic act, input logic [4:0] f, input logic last);
      chk1(seq_out.active, act);
      chk8({3'h0, seq_out.fifo}, {3'h0, f});
      chk1(seq_out.last, last);
   endtask

   function automatic fcc_event_t mkev(input logic [4:0] f, input logic h, input logic fe,
                                       input logic st, input logic [11:0] wc,
                                       input logic [11:0] rc, input logic [2:0] thr);
      mkev                    = '0;
      mkev.valid              = 1'b1;
      mkev.fifo               = f;
      mkev.hdlc               = h;
      mkev.frame_end          = fe;
      mkev.byte_step          = st;
      mkev.byte_write_counter = wc;
      mkev.byte_read_counter  = rc;
      mkev.irq_thr            = thr;
   endfunction

   // Presents one event for one cycle and waits until its results stand.
   task automatic fire(input fcc_event_t f);
      @(posedge core_clk);
      ev <= f;
      @(posedge core_clk);
      ev <= '0;
      #1;
   endtask

   task automatic ticks(input int n, input logic b, input logic tx);
      repeat (n) begin
         @(posedge core_clk);
         rx_bit      <= b;
         tx_bit_tick <= tx;
         rx_bit_tick <= !tx;
         @(posedge core_clk);
         tx_bit_tick <= 1'b0;
         rx_bit_tick <= 1'b0;
      end
      #1;
   endtask

   task automatic advance();
      @(posedge core_clk);
      seq_advance <= 1'b1;
      @(posedge core_clk);
      seq_advance <= 1'b0;
      #1;
   endtask

   // Counter wrap case: program, step once, read the status byte, clear it.
   task automatic wrap(input logic [4:0] f, input logic h, input logic [7:0] c,
                       input logic [11:0] wc, input logic [11:0] rc, input logic [2:0] thr,
                       input logic [7:0] x);
      u_host.put(f, {3'h0, f}, c, h);
      fire(mkev(f, h, 1'b0, 1'b1, wc, rc, thr));
      reg_is(ADDR_IRQ_STA, x);
      u_host.wr(ADDR_IRQ_STA, 8'hff);
   endtask

   // Main sequence: reset, table of ordinary cases, then the awkward ones.
   initial begin
      reset_n     = 1'b0;
      ev          = '0;
      tx_bit_tick = 1'b0;
      rx_bit_tick = 1'b0;
      rx_bit      = 1'b0;
      seq_advance = 1'b0;
      repeat (12) @(posedge core_clk);
      #1 chk1(irq, 1'b0);
      chk8(reg_rdata, 8'h00);
      @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      for (int i = 0; i < 32; i += 9) begin
         u_host.sel(5'(i));
         reg_is(ADDR_SEQ, 8'(i));
         reg_is(ADDR_CTRL, 8'h00);
      end
      reg_is(8'h10, 8'h00);
      foreach (ROWS[i]) begin
         u_host.put(5'h06, 8'h06, ROWS[i].ctrl, 1'b1);
         u_host.wr(ADDR_GLOBAL, ROWS[i].glb);
         e = mkev(5'h06, 1'b1, 1'b1, 1'b0, 12'h000, 12'h000, 3'h0);
         e.contention_lost = 1'b1;
         fire(e);
         chk1(repeat_frame, ROWS[i].rep);
         chk1(abort_frame, ROWS[i].abt);
         chk1(cfg_out.bit_error_test_enable, ROWS[i].bert);
         chk1(cfg_out.crc_suppress, ROWS[i].nocrc);
         chk8({3'h0, cfg_out.fifo}, 8'h06);
         chk1(irq, ROWS[i].irq);
         reg_is(ADDR_IRQ_STA, 8'h40);
         reg_is(ADDR_IRQ_MSK, {1'b0, ROWS[i].ctrl[0], 6'h00});
         u_host.wr(ADDR_IRQ_STA, 8'h40);
         #1 chk1(irq, 1'b0);
      end
      wrap(5'h07, 1'b1, 8'h04, 12'h008, 12'h003, 3'h0, 8'h80);
      wrap(5'h07, 1'b1, 8'h04, 12'h008, 12'h000, 3'h1, 8'h00);
      wrap(5'h06, 1'b1, 8'h04, 12'h003, 12'h010, 3'h0, 8'h40);
      wrap(5'h06, 1'b1, 8'h00, 12'h003, 12'h010, 3'h0, 8'h00);
      wrap(5'h06, 1'b0, 8'h00, 12'h000, 12'h020, 3'h2, 8'h40);
      // Transmit underrun within a frame, with and without the abort setting.
      u_host.put(5'h06, 8'h06, 8'h08, 1'b1);
      e = mkev(5'h06, 1'b1, 1'b0, 1'b0, 12'h055, 12'h055, 3'h0);
      e.in_frame            = 1'b1;
      e.frame_write_counter = 5'h03;
      e.frame_read_counter  = 5'h03;
      fire(e);
      chk1(tx_force_ones, 1'b1);
      u_host.rd(ADDR_STATE, d);
      chk1(d[STATE_ERR_BIT], 1'b1);
      ticks(15, 1'b1, 1'b1);
      chk1(tx_force_ones, 1'b1);
      ticks(1, 1'b1, 1'b1);
      chk1(tx_force_ones, 1'b0);
      u_host.wr(ADDR_STATE, 8'h01);
      e.frame_read_counter = 5'h02;
      fire(e);
      chk1(tx_force_ones, 1'b0);
      u_host.rd(ADDR_STATE, d);
      chk1(d[STATE_ERR_BIT], 1'b0);
      u_host.put(5'h06, 8'h06, 8'h00, 1'b1);
      e.frame_read_counter = 5'h03;
      fire(e);
      chk1(tx_force_ones, 1'b0);
      u_host.rd(ADDR_STATE, d);
      chk1(d[STATE_ERR_BIT], 1'b1);
      // Receive abort runs against the status byte.
      u_host.put(5'h07, 8'h07, 8'h08, 1'b1);
      ticks(7, 1'b1, 1'b0);
      e = mkev(5'h07, 1'b1, 1'b1, 1'b0, 12'h000, 12'h000, 3'h0);
      fire(e);
      chk1(rx_status_valid, 1'b1);
      chk8(rx_status_byte, STATUS_ABORT);
      ticks(6, 1'b1, 1'b0);
      e.crc_err = 1'b1;
      fire(e);
      chk8(rx_status_byte, STATUS_CRC_ERR);
      u_host.put(5'h07, 8'h07, 8'h00, 1'b1);
      ticks(8, 1'b1, 1'b0);
      e.crc_err = 1'b0;
      fire(e);
      chk8(rx_status_byte, STATUS_OK);
      // Sequence list of two entries, the second one ending the list.
      u_host.put(5'h04, 8'h09, 8'h00, 1'b1);
      u_host.put(5'h09, 8'h42, 8'h00, 1'b1);
      // The walker loads the start fifo while the mode is off and after the ending entry, so set it first.
      u_host.wr(ADDR_GLOBAL, 8'h20);
      u_host.wr(ADDR_GLOBAL, 8'h21);
      #1 seq_is(1'b1, 5'h04, 1'b0);
      advance();
      seq_is(1'b1, 5'h09, 1'b1);
      advance();
      seq_is(1'b1, 5'h04, 1'b0);
      u_host.wr(ADDR_GLOBAL, 8'h20);
      #1 chk1(seq_out.active, 1'b0);
      test_done();
   end
endmodule
